//--- shared/switch_scan_pkg.sv
// Constants and types shared by the switch scan sequencer.
package switch_scan_pkg;
    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int N_IN = 24;
    localparam int CH_W = 5;
    localparam int LVL_W = 3;
    localparam int ADC_W = 10;
    localparam int ACT_SEL_W = 3;
    localparam int POLL_SEL_W = 4;
    localparam int CNT_W = 32;
    localparam logic [CH_W-1:0] CH_FIRST = 5'h00;
    localparam logic [CH_W-1:0] CH_LAST = 5'h17;
    localparam logic [CH_W-1:0] CH_NONE = 5'h18;
    // ------------------------------------------------------------
    // Wetting levels: codes 0..5 give 0, 1, 2, 5, 10 and 15 mA.
    // ------------------------------------------------------------
    localparam logic [LVL_W-1:0] LVL_0MA = 3'h0;
    localparam logic [LVL_W-1:0] LVL_15MA = 3'h5;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int ACT_BASE_US = 64;
    localparam int ACT_MAX_US = 2048;
    localparam int POLL_BASE_MS = 2;
    localparam int POLL_MAX_MS = 4096;
    localparam int STARTUP_US = 200;
    localparam logic [ACT_SEL_W-1:0] ACT_SEL_MAX = 3'h5;
    localparam logic [POLL_SEL_W-1:0] POLL_SEL_MAX = 4'hb;
    localparam int ACT_BASE_CYC = ACT_BASE_US * CLK_MHZ;
    localparam int POLL_BASE_CYC = POLL_BASE_MS * 1000 * CLK_MHZ;
    localparam int STARTUP_CYC = STARTUP_US * CLK_MHZ;
    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_RAMP, ST_ACTIVE, ST_ISSUE, ST_WAIT, ST_PERIOD
    } scan_state_t;
endpackage : switch_scan_pkg

//--- rtl/switch_scan_sequencer.sv
// Switch scan sequencer: sweeps 24 inputs, stores status and raises change events.
`timescale 1ns/1ns
`default_nettype none
module switch_scan_sequencer
    import switch_scan_pkg::*;
#(
    parameter int RAMP_CYC = STARTUP_CYC,
    parameter int ACT_CYC = ACT_BASE_CYC,
    parameter int POLL_CYC = POLL_BASE_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic scan_start,
    input wire logic poll_mode,
    input wire logic [ACT_SEL_W-1:0] sample_window_field,
    input wire logic [POLL_SEL_W-1:0] poll_period_sel,
    input wire logic [N_IN-1:0] input_enable,
    input wire logic [N_IN-1:0] use_converter,
    input wire logic [N_IN-1:0] change_int_enable,
    input wire logic [N_IN*LVL_W/2-1:0] wetting_level_reg_lo,
    input wire logic [N_IN*LVL_W/2-1:0] wetting_level_reg_hi,
    input wire logic status_read,
    input wire logic sample_done,
    input wire logic sample_above,
    input wire logic [ADC_W-1:0] sample_value,
    output logic sample_req,
    output logic [CH_W-1:0] sample_ch,
    output logic sample_use_converter,
    output logic [N_IN*LVL_W-1:0] wetting_drive,
    output logic int_n,
    output logic switch_change_flag,
    output logic [N_IN-1:0] comparator_status,
    output logic [N_IN/2-1:0] converter_threshold_reg_lo,
    output logic [N_IN/2-1:0] converter_threshold_reg_hi,
    output logic [N_IN*ADC_W/2-1:0] analog_value_reg_first,
    output logic [N_IN*ADC_W/2-1:0] analog_value_reg_last
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Next enabled input at or above the given index, CH_NONE if none.
    function automatic logic [CH_W-1:0] next_enabled(input logic [CH_W:0] from,
                                                     input logic [N_IN-1:0] en);
        logic [CH_W-1:0] r;
        r = CH_NONE;
        for (int i = N_IN - 1; i >= 0; i--) begin
            if (en[i] && (i >= int'(from))) begin
                r = CH_W'(i);
            end
        end
        return r;
    endfunction : next_enabled

    // Out of range selections are held at the longest setting.
    function automatic logic [CNT_W-1:0] scaled(input int base, input int sel, input int max);
        int s;
        s = (sel > max) ? max : sel;
        return CNT_W'(base) << s;
    endfunction : scaled

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    scan_state_t state_r, state_nxt;
    logic [CH_W-1:0] ch_r, ch_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [CNT_W-1:0] per_r, per_nxt;
    logic first_r, first_nxt;
    logic chg_r, chg_nxt;
    logic chg_int_r, chg_int_nxt;
    logic req_r, req_nxt;
    logic use_conv_r, use_conv_nxt;
    logic flag_r, flag_nxt;
    logic int_n_r, int_n_nxt;
    logic [N_IN-1:0] comp_r, comp_nxt;
    logic [N_IN-1:0] conv_r, conv_nxt;
    logic [N_IN*ADC_W-1:0] ana_r, ana_nxt;
    logic [N_IN*LVL_W-1:0] wet_r, wet_nxt;
    logic [N_IN*LVL_W-1:0] levels;
    logic [CNT_W-1:0] act_len, poll_len;
    logic [CH_W-1:0] first_ch, after_ch;
    logic stored, cycle_end;

    assign levels = {wetting_level_reg_hi, wetting_level_reg_lo};
    assign act_len = scaled(ACT_CYC, int'(sample_window_field), int'(ACT_SEL_MAX));
    assign poll_len = scaled(POLL_CYC, int'(poll_period_sel), int'(POLL_SEL_MAX));
    assign first_ch = next_enabled({1'b0, CH_FIRST}, input_enable);
    assign after_ch = next_enabled({1'b0, ch_r} + 6'h01, input_enable);
    assign stored = use_converter[ch_r] ? conv_r[ch_r] : comp_r[ch_r];

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        ch_nxt = ch_r;
        cnt_nxt = cnt_r + 32'h1;
        per_nxt = (per_r == '1) ? per_r : per_r + 32'h1;
        first_nxt = first_r;
        chg_nxt = chg_r;
        chg_int_nxt = chg_int_r;
        req_nxt = 1'b0;
        comp_nxt = comp_r;
        conv_nxt = conv_r;
        ana_nxt = ana_r;
        cycle_end = 1'b0;
        unique case (state_r)
            ST_IDLE: begin
                if (scan_start) begin
                    state_nxt = ST_RAMP;
                    cnt_nxt = '0;
                    first_nxt = 1'b1;
                end
            end
            ST_RAMP: begin
                if (cnt_r >= CNT_W'(RAMP_CYC - 1)) begin
                    per_nxt = '0;
                    chg_nxt = 1'b0;
                    chg_int_nxt = 1'b0;
                    cnt_nxt = '0;
                    if (first_ch == CH_NONE) begin
                        state_nxt = ST_PERIOD;
                        cycle_end = 1'b1;
                    end else begin
                        ch_nxt = first_ch;
                        state_nxt = poll_mode ? ST_ACTIVE : ST_ISSUE;
                    end
                end
            end
            ST_ACTIVE: begin
                if (cnt_r >= act_len - 32'h1) begin
                    state_nxt = ST_ISSUE;
                end
            end
            ST_ISSUE: begin
                req_nxt = 1'b1;
                state_nxt = ST_WAIT;
            end
            ST_WAIT: begin
                if (sample_done) begin
                    if (use_converter[ch_r]) begin
                        conv_nxt[ch_r] = sample_above;
                        ana_nxt[ch_r*ADC_W +: ADC_W] = sample_value;
                    end else begin
                        comp_nxt[ch_r] = sample_above;
                    end
                    if (!first_r && (sample_above != stored)) begin
                        chg_nxt = 1'b1;
                        chg_int_nxt = chg_int_r | change_int_enable[ch_r];
                    end
                    cnt_nxt = '0;
                    if (after_ch == CH_NONE) begin
                        state_nxt = ST_PERIOD;
                        cycle_end = 1'b1;
                    end else begin
                        ch_nxt = after_ch;
                        state_nxt = poll_mode ? ST_ACTIVE : ST_ISSUE;
                    end
                end
            end
            ST_PERIOD: begin
                if (per_r >= poll_len - 32'h1) begin
                    per_nxt = '0;
                    chg_nxt = 1'b0;
                    chg_int_nxt = 1'b0;
                    cnt_nxt = '0;
                    if (first_ch == CH_NONE) begin
                        cycle_end = 1'b1;
                    end else begin
                        ch_nxt = first_ch;
                        state_nxt = poll_mode ? ST_ACTIVE : ST_ISSUE;
                    end
                end
            end
        endcase
        if (cycle_end) begin
            first_nxt = 1'b0;
        end
        if (!scan_start) begin
            state_nxt = ST_IDLE;
            req_nxt = 1'b0;
        end
        use_conv_nxt = req_nxt & use_converter[ch_r];
    end

    // ------------------------------------------------------------
    // Change event and interrupt pin
    // ------------------------------------------------------------
    // A completion in the same cycle as the host read keeps the event.
    always_comb begin
        flag_nxt = status_read ? 1'b0 : flag_r;
        int_n_nxt = status_read ? 1'b1 : int_n_r;
        if (cycle_end && (first_r || chg_nxt)) begin
            flag_nxt = 1'b1;
            if (first_r || chg_int_nxt) begin
                int_n_nxt = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Wetting current drive
    // ------------------------------------------------------------
    // Built from the next state so the drive lines up with the sequencer. In polling
    // the current stays on until the result is taken, so every sample sees a wetted input.
    always_comb begin
        wet_nxt = '0;
        for (int i = 0; i < N_IN; i++) begin
            if (input_enable[i] && (state_nxt != ST_IDLE)) begin
                if (!poll_mode) begin
                    wet_nxt[i*LVL_W +: LVL_W] = levels[i*LVL_W +: LVL_W];
                end else if ((ch_nxt == CH_W'(i)) &&
                             !(state_nxt inside {ST_RAMP, ST_PERIOD})) begin
                    wet_nxt[i*LVL_W +: LVL_W] = levels[i*LVL_W +: LVL_W];
                end
            end
            if (wet_nxt[i*LVL_W +: LVL_W] > LVL_15MA) begin
                wet_nxt[i*LVL_W +: LVL_W] = LVL_0MA;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
            ch_r <= CH_FIRST;
            cnt_r <= '0;
            per_r <= '0;
            first_r <= 1'b1;
            chg_r <= 1'b0;
            chg_int_r <= 1'b0;
            req_r <= 1'b0;
            use_conv_r <= 1'b0;
            flag_r <= 1'b0;
            int_n_r <= 1'b1;
            comp_r <= '0;
            conv_r <= '0;
            ana_r <= '0;
            wet_r <= '0;
        end else if (ce) begin
            state_r <= state_nxt;
            ch_r <= ch_nxt;
            cnt_r <= cnt_nxt;
            per_r <= per_nxt;
            first_r <= first_nxt;
            chg_r <= chg_nxt;
            chg_int_r <= chg_int_nxt;
            req_r <= req_nxt;
            use_conv_r <= use_conv_nxt;
            flag_r <= flag_nxt;
            int_n_r <= int_n_nxt;
            comp_r <= comp_nxt;
            conv_r <= conv_nxt;
            ana_r <= ana_nxt;
            wet_r <= wet_nxt;
        end
    end

    assign sample_req = req_r;
    assign sample_ch = ch_r;
    assign sample_use_converter = use_conv_r;
    assign wetting_drive = wet_r;
    assign int_n = int_n_r;
    assign switch_change_flag = flag_r;
    assign comparator_status = comp_r;
    assign converter_threshold_reg_lo = conv_r[N_IN/2-1:0];
    assign converter_threshold_reg_hi = conv_r[N_IN-1:N_IN/2];
    assign analog_value_reg_first = ana_r[N_IN*ADC_W/2-1:0];
    assign analog_value_reg_last = ana_r[N_IN*ADC_W-1:N_IN*ADC_W/2];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_sample_taken;
        ce && state_r == ST_WAIT && sample_done && scan_start;
    endsequence
    sequence s_ramp_ends;
        ce && state_r == ST_RAMP && scan_start && cnt_r >= CNT_W'(RAMP_CYC - 1);
    endsequence

    req_one_cycle_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && req_r |=> !req_r || !ce) else $error("sample request longer than one cycle");
    ramp_before_sample_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && state_r == ST_RAMP && state_nxt == ST_ISSUE |-> cnt_r >= CNT_W'(RAMP_CYC - 1))
        else $error("sampling began before ramp delay");
    first_cycle_int_a: assert property (@(posedge clk) disable iff (!rstn)
        s_sample_taken ##0 (first_r && after_ch == CH_NONE && !status_read)
        |=> !int_n && switch_change_flag) else $error("first cycle raised no interrupt");
    read_clears_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && status_read && !cycle_end |=> int_n && !switch_change_flag)
        else $error("status read did not clear event");
    quiet_no_int_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && !first_r && !chg_nxt && int_n && !flag_r |=> int_n && !switch_change_flag)
        else $error("interrupt without status change");
    poll_one_input_a: assert property (@(posedge clk) disable iff (!rstn)
        poll_mode && $stable(poll_mode) |-> $onehot0(wetting_on_mask()))
        else $error("more than one input driven in polling");
    ascending_order_a: assert property (@(posedge clk) disable iff (!rstn)
        s_sample_taken ##0 (after_ch != CH_NONE) |=> ch_r > $past(ch_r))
        else $error("inputs not sampled in ascending order");
    default_update_a: assert property (@(posedge clk) disable iff (!rstn)
        s_sample_taken ##0 !use_converter[ch_r] |=> comp_r[$past(ch_r)] == $past(sample_above))
        else $error("stored default not updated");
    ramp_then_go_a: assert property (@(posedge clk) disable iff (!rstn)
        s_ramp_ends |=> per_r == '0) else $error("poll period not restarted");

    function automatic logic [N_IN-1:0] wetting_on_mask();
        logic [N_IN-1:0] m;
        m = '0;
        for (int i = 0; i < N_IN; i++) begin
            m[i] = |wet_r[i*LVL_W +: LVL_W];
        end
        return m;
    endfunction : wetting_on_mask
endmodule : switch_scan_sequencer
`default_nettype wire

//--- tb/scan_front_model.sv
// Behavioural model of the comparator and converter that answer sample requests.
`timescale 1ns/1ns
`default_nettype none
module scan_front_model
    import switch_scan_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic sample_req,
    input wire logic [CH_W-1:0] sample_ch,
    input wire logic [N_IN-1:0] sw_above,
    input wire logic [N_IN*ADC_W-1:0] sw_value,
    input wire logic [3:0] dly,
    output logic sample_done,
    output logic sample_above,
    output logic [ADC_W-1:0] sample_value
);
    logic busy_r;
    logic [3:0] wait_r;
    logic [CH_W-1:0] ch_r;
    // Result lines toggle between answers, so a design that takes them
    // outside the done pulse sees garbage rather than a lucky match.
    always @(posedge clk) begin
        sample_done <= 1'b0;
        sample_above <= ~sample_above;
        sample_value <= ~sample_value;
        if (!rstn) begin
            busy_r <= 1'b0;
            sample_above <= 1'b0;
            sample_value <= 10'h000;
        end else if (sample_req) begin
            busy_r <= 1'b1;
            ch_r <= sample_ch;
            wait_r <= dly;
        end else if (busy_r && wait_r > 4'h1) begin
            wait_r <= wait_r - 4'h1;
        end else if (busy_r) begin
            busy_r <= 1'b0;
            sample_done <= 1'b1;
            sample_above <= sw_above[ch_r];
            sample_value <= sw_value[ch_r*ADC_W+:ADC_W];
        end
    end
endmodule : scan_front_model
`default_nettype wire

//--- tb/switch_scan_sequencer_bench.sv
// Self-checking bench for the switch scan sequencer.
`timescale 1ns/1ns
`default_nettype none
`define CHECK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module switch_scan_sequencer_bench
    import switch_scan_pkg::*;
;
    localparam int RAMP = 4;
    localparam int ACT = 8;
    localparam int POLL = 400;
    logic clk = 1'b0, rstn = 1'b0, scan_start = 1'b0, poll_mode = 1'b0, status_read = 1'b0;
    logic [ACT_SEL_W-1:0] win_sel = 3'h0;
    logic [POLL_SEL_W-1:0] per_sel = 4'h0;
    logic [N_IN-1:0] en = 24'h7fffef, conv = 24'h0f0f0f, int_en = 24'hffff7f;
    logic [N_IN-1:0] sw_above = 24'h5a5a5a;
    logic [N_IN*LVL_W-1:0] lvl, wetting_drive;
    logic [N_IN*ADC_W-1:0] sw_value;
    logic [3:0] dly = 4'h1;
    logic sample_req, sample_done, sample_above, sample_use_converter, int_n, flag;
    logic [CH_W-1:0] sample_ch, prev_ch;
    logic [ADC_W-1:0] sample_value;
    logic [N_IN-1:0] comp_st;
    logic [N_IN/2-1:0] cth_lo, cth_hi;
    logic [N_IN*ADC_W/2-1:0] av_lo, av_hi;
    int n_errors = 0, n_checks = 0, n_sweeps = 0, per_cnt = 0, on_cnt = 0;
    time sweep_t[$];
    always #4 clk = ~clk;
    initial begin
        for (int i = 0; i < N_IN; i++) begin
            lvl[3*i+:3] = 3'(i);
            sw_value[10*i+:10] = 10'(i * 37 + 5);
        end
    end
    switch_scan_sequencer #(.RAMP_CYC(RAMP), .ACT_CYC(ACT), .POLL_CYC(POLL)) i_switch_scan_sequencer (
        .clk(clk), .rstn(rstn), .ce(1'b1), .scan_start(scan_start), .poll_mode(poll_mode),
        .sample_window_field(win_sel), .poll_period_sel(per_sel), .input_enable(en),
        .use_converter(conv), .change_int_enable(int_en),
        .wetting_level_reg_lo(lvl[35:0]), .wetting_level_reg_hi(lvl[71:36]),
        .status_read(status_read), .sample_done(sample_done), .sample_above(sample_above),
        .sample_value(sample_value), .sample_req(sample_req), .sample_ch(sample_ch),
        .sample_use_converter(sample_use_converter), .wetting_drive(wetting_drive),
        .int_n(int_n), .switch_change_flag(flag), .comparator_status(comp_st),
        .converter_threshold_reg_lo(cth_lo), .converter_threshold_reg_hi(cth_hi),
        .analog_value_reg_first(av_lo), .analog_value_reg_last(av_hi));
    scan_front_model i_scan_front_model (
        .clk(clk), .rstn(rstn), .sample_req(sample_req), .sample_ch(sample_ch),
        .sw_above(sw_above), .sw_value(sw_value), .dly(dly), .sample_done(sample_done),
        .sample_above(sample_above), .sample_value(sample_value));
    function automatic logic [N_IN*LVL_W-1:0] exp_drive();
        logic [N_IN*LVL_W-1:0] d;
        d = '0;
        for (int i = 0; i < N_IN; i++) begin
            if (en[i] && lvl[3*i+:3] <= LVL_15MA) d[3*i+:3] = lvl[3*i+:3];
        end
        return d;
    endfunction : exp_drive
    // ----------------------------------------------------------------
    // Monitor of every request and of the current sources
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        int n_on;
        n_on = 0;
        for (int i = 0; i < N_IN; i++) n_on += int'(wetting_drive[3*i+:3] != 3'h0);
        if (rstn && scan_start && poll_mode) `CHECK(n_on <= 1, 1'b1)
        if (poll_mode && wetting_drive[5:3] != 3'h0) on_cnt++;
        else if (on_cnt != 0) begin
            `CHECK(on_cnt >= 2*ACT && on_cnt <= 2*ACT + int'(dly) + 3, 1'b1)
            on_cnt = 0;
        end
        if (sample_req) begin
            `CHECK(sample_use_converter, conv[sample_ch])
            `CHECK(en[sample_ch], 1'b1)
            if (!poll_mode) `CHECK(wetting_drive, exp_drive())
            if (sample_ch != 5'h00) `CHECK(sample_ch > prev_ch, 1'b1)
            else sweep_t.push_back($time);
            per_cnt = (sample_ch == 5'h00) ? 1 : per_cnt + 1;
            if (sample_ch == 5'h16) begin
                `CHECK(per_cnt, 22)
                n_sweeps++;
            end
            prev_ch = sample_ch;
        end
    end
    // ----------------------------------------------------------------
    // Shared steps
    // ----------------------------------------------------------------
    task automatic start_scan(input int lo, input int hi);
        int n;
        n = 0;
        @(negedge clk) scan_start = 1'b1;
        while (!sample_req && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHECK(n >= lo && n <= hi, 1'b1)
    endtask : start_scan
    task automatic wait_sweep();
        int n0;
        n0 = n_sweeps;
        for (int k = 0; k < 4000 && n_sweeps == n0; k++) @(negedge clk);
        `CHECK(n_sweeps != n0, 1'b1)
        repeat (int'(dly) + 6) @(negedge clk);
    endtask : wait_sweep
    task automatic check_store();
        logic [N_IN-1:0] c;
        logic [N_IN*ADC_W-1:0] a;
        c = {cth_hi, cth_lo};
        a = {av_hi, av_lo};
        for (int i = 0; i < N_IN; i++) begin
            if (en[i] && conv[i]) begin
                `CHECK(c[i], sw_above[i])
                `CHECK(a[10*i+:10], sw_value[10*i+:10])
            end else if (en[i]) `CHECK(comp_st[i], sw_above[i])
        end
    endtask : check_store
    task automatic host_read();
        @(negedge clk) status_read = 1'b1;
        @(negedge clk) status_read = 1'b0;
        @(negedge clk);
        `CHECK(flag, 1'b0)
        `CHECK(int_n, 1'b1)
    endtask : host_read
    task automatic check_irq(input logic f, input logic n);
        `CHECK(flag, f)
        `CHECK(int_n, n)
    endtask : check_irq
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_continuous();
        start_scan(RAMP + 1, RAMP + 2);
        wait_sweep();
        check_irq(1'b1, 1'b0);
        check_store();
        host_read();
        wait_sweep();
        check_irq(1'b0, 1'b1);
        wait_sweep();
        `CHECK(sweep_t[$] - sweep_t[$-1], time'(POLL * 8))
        sw_above[9] = ~sw_above[9];
        sw_above[13] = ~sw_above[13];
        wait_sweep();
        check_irq(1'b1, 1'b0);
        check_store();
        host_read();
        scan_start = 1'b0;
        repeat (4) @(negedge clk);
    endtask : t_continuous
    task automatic t_polling();
        poll_mode = 1'b1;
        dly = 4'h4;
        win_sel = 3'h1;
        per_sel = 4'h1;
        start_scan(RAMP + 2 * ACT + 1, RAMP + 2 * ACT + 2);
        wait_sweep();
        check_irq(1'b1, 1'b0);
        check_store();
        host_read();
        wait_sweep();
        check_irq(1'b0, 1'b1);
        `CHECK(sweep_t[$] - sweep_t[$-1], time'(POLL * 2 * 8))
        // Input 7 has its pin enable off: the flag must rise, the pin must not.
        sw_above[7] = ~sw_above[7];
        wait_sweep();
        check_irq(1'b1, 1'b1);
        check_store();
        host_read();
        // A change that reverts inside the idle gap is never sampled.
        sw_above[5] = ~sw_above[5];
        repeat (20) @(negedge clk);
        sw_above[5] = ~sw_above[5];
        wait_sweep();
        `CHECK(flag, 1'b0)
        `CHECK(int_n, 1'b1)
        check_store();
    endtask : t_polling
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        t_continuous();
        t_polling();
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        give_verdict();
    end
endmodule : switch_scan_sequencer_bench
`default_nettype wire
